/* inc/jtag_prog_map.svh */
/*
  Constants of the serial programming port: instruction codes, register
  widths, erased-cell values and the length of the IDCODE run.
  Assumes it is included once, by its bare name, before the type package.
*/
`ifndef JTAG_PROG_MAP_SVH
`define JTAG_PROG_MAP_SVH

// ==========================================================
// Instruction register
`define IR_W 8
`define INS_IDCODE 8'h16
`define INS_BYPASS 8'hFF
`define INS_EXTEST 8'h00
`define INS_SAMPLE 8'h1C
`define INS_OUT_HIGHZ 8'h18
`define INS_PROG_EN 8'h15
`define INS_PROG_DIS 8'h1E
`define INS_PROG_FUSE 8'h09
`define INS_BULK_ERASE 8'h03
`define INS_CFG_SHIFT 8'h2D
`define INS_CFG_PROG 8'h2E
`define INS_UES_SHIFT 8'h3A
`define INS_UES_PROG 8'h3B

// ==========================================================
// Data registers and pins
`define DR_W 32
`define BND_W 6
`define DIG_W 16
`define HV_W 4
`define ID_VALUE 32'h0A5C_3001
`define ID_RUN 3'h4
`define NV_BLANK 32'hFFFF_FFFF

`endif

/* inc/jtag_prog_pkg.sv */
/*
  Types of the serial programming port: TAP states, nonvolatile operations
  and the nonvolatile content record.
  Assumes jtag_prog_map.svh is on the include path.
*/
`include "jtag_prog_map.svh"

package jtag_prog_pkg;

  // ==========================================================
  // TAP controller states
  typedef enum logic [3:0] {
    TAP_RESET = 4'b0000, TAP_IDLE = 4'b0001, TAP_SEL_DR = 4'b0010, TAP_CAP_DR = 4'b0011,
    TAP_SH_DR = 4'b0100, TAP_EX1_DR = 4'b0101, TAP_PA_DR = 4'b0110, TAP_EX2_DR = 4'b0111,
    TAP_UPD_DR = 4'b1000, TAP_SEL_IR = 4'b1001, TAP_CAP_IR = 4'b1010, TAP_SH_IR = 4'b1011,
    TAP_EX1_IR = 4'b1100, TAP_PA_IR = 4'b1101, TAP_EX2_IR = 4'b1110, TAP_UPD_IR = 4'b1111
  } tap_state_e;

  // ==========================================================
  // Nonvolatile operations
  typedef enum logic [1:0] {
    NV_PROG_CFG = 2'b00, NV_PROG_UES = 2'b01, NV_PROG_FUSE = 2'b10, NV_ERASE = 2'b11
  } nv_op_e;

  typedef struct packed {
    logic [`DR_W-1:0] cfg;
    logic [`DR_W-1:0] user_signature;
    logic fuse;
  } nv_s;

endpackage

/* rtl/tap_fsm.sv */
/*
  Sixteen-state test access port controller, stepped by TMS on TCK.
  Assumes tck_rst is synchronous to tck and tms is sampled on the rising edge.
*/
`timescale 1ns/1ns

module tap_fsm
  import jtag_prog_pkg::*;
(
  // Link clock and reset
  input wire logic tck,
  input wire logic tck_rst,
  // Mode select
  input wire logic tms,
  // State
  output tap_state_e state
);

  tap_state_e next_state;

  always_comb
  begin
    case (state)
      TAP_RESET: next_state = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: next_state = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: next_state = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_state = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: next_state = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: next_state = tms ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR: next_state = tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: next_state = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: next_state = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: next_state = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: next_state = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: next_state = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: next_state = tms ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR: next_state = tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: next_state = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: next_state = tms ? TAP_SEL_DR : TAP_IDLE;
      default: next_state = TAP_RESET;
    endcase
  end

  // Power-on state is Test-Logic-Reset
  always_ff @(posedge tck)
  begin
    if (tck_rst)
      state <= TAP_RESET;
    else
      state <= next_state;
  end

endmodule

/* rtl/jtag_prog_port.sv */
/*
  Serial programming port: TAP, instruction and data registers, selection
  of the serial input between TDI and the alternate input, nonvolatile
  configuration, signature and security fuse, and output gating while only
  the programming supply is present.
  Assumes tck is the link clock, tdi/tms/alternate_serial_in are synchronous
  to it, and the strap pull-up lives in the pad.
*/
// Summary of operation
// - Four-wire boundary-scan port at logic levels.
// - Four IDCODE loads with strap high select alternate.
// - Alternate input holds until Test-Logic-Reset.
// - Strap pulled up; low forces alternate input.
// - Test-Logic-Reset loads IDCODE into instruction register.
// - Programming supply only: outputs off, FETs low.
// - Instruction picks data register and its operation.
// - Shift configuration, then program instruction stores it.
// - Fuse blocks configuration readout; erase clears it.
// - Thirty-two bit nonvolatile user signature.
// - Bypass and boundary-scan registers are present.
// - Sample on rising TCK, drive TDO falling.
// - TMS high five clocks reaches Test-Logic-Reset.
// - IDCODE is 0001 0110, reads 32 bits.
// - Capture-IR loads the IDCODE pattern.
`timescale 1ns/1ns

module jtag_prog_port
  import jtag_prog_pkg::*;
#(
  // Identification value is arbitrary
  parameter logic [31:0] ID_VALUE = `ID_VALUE
)
(
  // System clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Test access port: four wires at logic levels
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic alternate_serial_in,
  input wire logic input_select_strap,
  output logic tdo,
  output logic tdo_oe,
  // Supply pins
  input wire logic programming_supply_pin,
  input wire logic main_supply_on,
  // Core side
  input wire logic [`DIG_W-1:0] core_dig_out,
  input wire logic [`DIG_W-1:0] core_dig_oe,
  input wire logic [`HV_W-1:0] core_hv_out,
  input wire logic [`HV_W-1:0] hv_fet_mode,
  output logic [`BND_W-1:0] core_in,
  // Pin side
  input wire logic [`BND_W-1:0] pin_in,
  output logic [`DIG_W-1:0] dig_out,
  output logic [`DIG_W-1:0] dig_oe,
  output logic [`HV_W-1:0] high_voltage_output,
  output logic [`HV_W-1:0] hv_oe,
  // Status
  output logic alt_input_active,
  output logic program_mode,
  output nv_s nv_content
);

  // ==========================================================
  // Link-domain reset and pin synchronisers
  logic [1:0] rst_sync;
  logic [1:0] strap_sync;
  logic [`BND_W-1:0] bnd_m;
  logic [`BND_W-1:0] bnd_pins;
  wire tck_rst = ~rst_sync[1];
  wire strap_s = strap_sync[1];

  always_ff @(posedge tck)
  begin
    rst_sync <= {rst_sync[0], nrst};
    strap_sync <= {strap_sync[0], input_select_strap};
    bnd_m <= pin_in;
    bnd_pins <= bnd_m;
  end

  tap_state_e tap;

  tap_fsm u_tap (
    .tck(tck),
    .tck_rst(tck_rst),
    .tms(tms),
    .state(tap)
  );

  // ==========================================================
  // Instruction register and serial input selection
  logic [`IR_W-1:0] ir;
  logic [`IR_W-1:0] ir_sh;
  logic [2:0] id_run;
  logic alt_latched;
  logic use_alt;
  logic prog_en;
  logic armed;
  nv_op_e arm_op;

  wire in_reset = (tap == TAP_RESET);
  wire upd_ir = (tap == TAP_UPD_IR);
  wire new_id = upd_ir && (ir_sh == `INS_IDCODE);
  wire serial_in = use_alt ? alternate_serial_in : tdi;
  wire [2:0] next_id_run = in_reset || (upd_ir && !new_id) ? 3'h0 :
                           new_id && (id_run != `ID_RUN) ? id_run + 3'h1 : id_run;
  wire next_alt_latched = !in_reset && (alt_latched || (new_id && id_run == `ID_RUN - 3'h1));
  wire prog_ins = (ir_sh == `INS_CFG_PROG) || (ir_sh == `INS_UES_PROG) ||
                  (ir_sh == `INS_PROG_FUSE) || (ir_sh == `INS_BULK_ERASE);
  wire nv_op_e next_op = (ir_sh == `INS_CFG_PROG) ? NV_PROG_CFG :
                         (ir_sh == `INS_UES_PROG) ? NV_PROG_UES :
                         (ir_sh == `INS_PROG_FUSE) ? NV_PROG_FUSE : NV_ERASE;

  always_ff @(posedge tck)
  begin
    if (tck_rst || in_reset)
      ir <= `INS_IDCODE;
    else if (upd_ir)
      ir <= ir_sh;
  end

  always_ff @(posedge tck)
  begin
    if (tap == TAP_CAP_IR)
      ir_sh <= `INS_IDCODE;
    else if (tap == TAP_SH_IR)
      ir_sh <= {serial_in, ir_sh[`IR_W-1:1]};
  end

  // Counting uses Update-IR only, so TMS/TCK walks alone suffice
  always_ff @(posedge tck)
  begin
    if (tck_rst)
    begin
      id_run <= 3'h0;
      alt_latched <= 1'b0;
      use_alt <= 1'b0;
    end
    else
    begin
      id_run <= next_id_run;
      alt_latched <= next_alt_latched;
      use_alt <= !strap_s || next_alt_latched;
    end
  end

  // Programming is allowed only between enable and disable; ops launch on Run-Test/Idle
  always_ff @(posedge tck)
  begin
    if (tck_rst || in_reset)
    begin
      prog_en <= 1'b0;
      armed <= 1'b0;
      arm_op <= NV_PROG_CFG;
    end
    else if (upd_ir)
    begin
      prog_en <= (ir_sh == `INS_PROG_EN) || (prog_en && ir_sh != `INS_PROG_DIS);
      armed <= prog_ins && prog_en;
      arm_op <= next_op;
    end
    else if (tap == TAP_IDLE)
      armed <= 1'b0;
  end

  // ==========================================================
  // Data registers
  logic [`DR_W-1:0] dr_sh;
  logic [`DR_W-1:0] cfg_stage;
  logic [`DR_W-1:0] ues_stage;
  nv_s mirror;

  wire is_id = (ir == `INS_IDCODE);
  wire is_cfg = (ir == `INS_CFG_SHIFT);
  wire is_ues = (ir == `INS_UES_SHIFT);
  wire is_bnd = (ir == `INS_SAMPLE) || (ir == `INS_EXTEST);
  wire is_byp = !(is_id || is_cfg || is_ues || is_bnd);
  wire [`DR_W-1:0] cap_val = is_id ? ID_VALUE :
                             is_cfg ? (mirror.fuse ? '0 : mirror.cfg) :
                             is_ues ? mirror.user_signature :
                             is_bnd ? {{(`DR_W-`BND_W){1'b0}}, bnd_pins} : '0;
  wire [`DR_W-1:0] sh_val = is_byp ? {{(`DR_W-1){1'b0}}, serial_in} :
                            is_bnd ? {{(`DR_W-`BND_W){1'b0}}, serial_in, dr_sh[`BND_W-1:1]} :
                            {serial_in, dr_sh[`DR_W-1:1]};

  // Fuse forces configuration capture to zero; bypass captures zero and boundary captures the pins, whatever the fuse
  always_ff @(posedge tck)
  begin
    if (tap == TAP_CAP_DR)
      dr_sh <= cap_val;
    else if (tap == TAP_SH_DR)
      dr_sh <= sh_val;
  end

  always_ff @(posedge tck)
  begin
    if (tck_rst)
    begin
      cfg_stage <= '0;
      ues_stage <= '0;
    end
    else if (tap == TAP_UPD_DR && is_cfg)
      cfg_stage <= dr_sh;
    else if (tap == TAP_UPD_DR && is_ues)
      ues_stage <= dr_sh;
  end

  // TDO moves on the falling edge so the far end samples it mid-bit
  wire sh_any = (tap == TAP_SH_DR) || (tap == TAP_SH_IR);
  always_ff @(negedge tck)
  begin
    if (tck_rst)
    begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else
    begin
      tdo <= (tap == TAP_SH_IR) ? ir_sh[0] : dr_sh[0];
      tdo_oe <= sh_any;
    end
  end

  // ==========================================================
  // Nonvolatile handshake: request toggle out, acknowledge toggle back
  logic req_tgl;
  logic ack_tgl;
  logic [2:0] ack_sync;
  logic [2:0] req_sync;
  wire busy = (req_tgl != ack_sync[2]);
  wire ack_evt = ack_sync[1] ^ ack_sync[2];

  // A launch while the previous one is in flight is dropped
  always_ff @(posedge tck)
  begin
    if (tck_rst)
    begin
      req_tgl <= 1'b0;
      ack_sync <= 3'h0;
      mirror <= '{`NV_BLANK, `NV_BLANK, 1'b0};
    end
    else
    begin
      ack_sync <= {ack_sync[1:0], ack_tgl};
      if (armed && tap == TAP_IDLE && !busy)
        req_tgl <= ~req_tgl;
      if (ack_evt)
        mirror <= nv_content;
    end
  end

  // Stage and op stay still until the acknowledge returns, so they cross as quasi-static words
  wire req_evt = req_sync[1] ^ req_sync[2];

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      req_sync <= 3'h0;
      ack_tgl <= 1'b0;
      nv_content <= '{`NV_BLANK, `NV_BLANK, 1'b0};
    end
    else
    begin
      req_sync <= {req_sync[1:0], req_tgl};
      if (req_evt)
      begin
        ack_tgl <= ~ack_tgl;
        case (arm_op)
          NV_PROG_CFG: nv_content.cfg <= cfg_stage;
          NV_PROG_UES: nv_content.user_signature <= ues_stage;
          NV_PROG_FUSE: nv_content.fuse <= 1'b1;
          NV_ERASE: nv_content <= '{`NV_BLANK, `NV_BLANK, 1'b0};
          default: nv_content <= nv_content;
        endcase
      end
    end
  end

  // ==========================================================
  // Output gating in the system domain
  logic [1:0] aps_sync;
  logic [1:0] main_sync;
  logic [1:0] hiz_sync;
  logic [1:0] alt_sync;
  logic [1:0] pe_sync;
  logic [`BND_W-1:0] in_m;
  logic [`BND_W-1:0] in_s;
  logic ir_hiz;

  always_ff @(posedge tck)
  begin
    if (tck_rst)
      ir_hiz <= 1'b0;
    else
      ir_hiz <= (ir == `INS_OUT_HIGHZ);
  end

  wire aps_only = aps_sync[1] && !main_sync[1];
  wire hiz = aps_only || hiz_sync[1];

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      aps_sync <= 2'h0;
      main_sync <= 2'h0;
      hiz_sync <= 2'h0;
      alt_sync <= 2'h0;
      pe_sync <= 2'h0;
      in_m <= '0;
      in_s <= '0;
    end
    else
    begin
      aps_sync <= {aps_sync[0], programming_supply_pin};
      main_sync <= {main_sync[0], main_supply_on};
      hiz_sync <= {hiz_sync[0], ir_hiz};
      alt_sync <= {alt_sync[0], use_alt};
      pe_sync <= {pe_sync[0], prog_en};
      in_m <= pin_in;
      in_s <= in_m;
    end
  end

  // FET-mode outputs pull low instead of floating so the gates stay off
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      dig_out <= '0;
      dig_oe <= '0;
      high_voltage_output <= '0;
      hv_oe <= '0;
      core_in <= '0;
    end
    else
    begin
      dig_out <= hiz ? '0 : core_dig_out;
      dig_oe <= hiz ? '0 : core_dig_oe;
      high_voltage_output <= hiz ? '0 : core_hv_out;
      hv_oe <= hiz ? hv_fet_mode : {`HV_W{1'b1}};
      core_in <= aps_only ? '0 : in_s;
    end
  end

  assign alt_input_active = alt_sync[1];
  assign program_mode = pe_sync[1];

  // ==========================================================
  // Assertions
  a_tms_reset_path: assert property (@(posedge tck) disable iff (tck_rst)
    tms [*5] |=> tap == TAP_RESET) else $error("five TMS highs did not reach reset");
  a_reset_ir_idcode: assert property (@(posedge tck) disable iff (tck_rst)
    tap == TAP_RESET |=> ir == `INS_IDCODE) else $error("reset did not load IDCODE");
  a_capture_ir_id: assert property (@(posedge tck) disable iff (tck_rst)
    tap == TAP_CAP_IR |=> ir_sh == `INS_IDCODE) else $error("Capture-IR pattern wrong");
  a_four_id_alt: assert property (@(posedge tck) disable iff (tck_rst)
    new_id && id_run == 3'h3 && !in_reset |=> use_alt && alt_latched) else $error("fourth IDCODE missed");
  a_strap_low_alt: assert property (@(posedge tck) disable iff (tck_rst)
    !strap_s |=> use_alt) else $error("strap low did not select alternate");
  a_reset_restores_tdi: assert property (@(posedge tck) disable iff (tck_rst)
    in_reset && strap_s |=> !use_alt) else $error("reset did not restore TDI");
  a_alt_holds: assert property (@(posedge tck) disable iff (tck_rst)
    alt_latched && !in_reset |=> alt_latched) else $error("alternate dropped before reset");
  a_run_clears: assert property (@(posedge tck) disable iff (tck_rst)
    upd_ir && !new_id |=> id_run == 3'h0 && !alt_latched == !$past(alt_latched))
    else $error("IDCODE run not cleared");
  a_id_capture: assert property (@(posedge tck) disable iff (tck_rst)
    tap == TAP_CAP_DR && is_id |=> dr_sh == ID_VALUE) else $error("IDCODE capture wrong");
  a_fuse_blocks: assert property (@(posedge tck) disable iff (tck_rst)
    tap == TAP_CAP_DR && is_cfg && mirror.fuse |=> dr_sh == '0) else $error("fuse did not block readout");
  a_ues_capture: assert property (@(posedge tck) disable iff (tck_rst)
    tap == TAP_CAP_DR && is_ues |=> dr_sh == $past(mirror.user_signature)) else $error("signature capture wrong");
  a_bypass_path: assert property (@(posedge tck) disable iff (tck_rst)
    tap == TAP_SH_DR && is_byp |=> dr_sh[0] == $past(serial_in)) else $error("bypass bit wrong");
  a_tdo_oe_shift: assert property (@(negedge tck) disable iff (tck_rst)
    sh_any |=> tdo_oe) else $error("TDO not enabled in shift");
  a_nv_program: assert property (@(posedge sys_clk) disable iff (!nrst)
    req_evt && arm_op == NV_PROG_CFG |=> nv_content.cfg == $past(cfg_stage)) else $error("config not stored");
  a_aps_outputs: assert property (@(posedge sys_clk) disable iff (!nrst)
    aps_only |=> dig_oe == '0 && high_voltage_output == '0 && core_in == '0) else $error("outputs live on PROGRAMMING_SUPPLY_PIN");

  c_alt_by_ids: cover property (@(posedge tck) disable iff (tck_rst) new_id ##1 !use_alt ##[1:40] use_alt);
  c_cfg_program: cover property (@(posedge sys_clk) disable iff (!nrst) req_evt && arm_op == NV_PROG_CFG);
  c_fuse_read: cover property (@(posedge tck) disable iff (tck_rst) tap == TAP_CAP_DR && is_cfg && mirror.fuse);
  c_aps_only: cover property (@(posedge sys_clk) disable iff (!nrst) aps_only);

endmodule

/* sim/jtag_host_model.sv */
/*
  Behavioural test controller that walks the link of the serial programming port.
  Assumes one task runs at a time and that every task starts and ends in Run-Test/Idle.
*/
`timescale 1ns/1ns

module jtag_host_model
(
  // Link pins
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic alternate_serial_in,
  input wire logic tdo
);
  logic use_alt;
  logic last;

  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    alternate_serial_in = 1'b0;
    use_alt = 1'b0;
    last = 1'b0;
  end

  // ==========================================================
  // One link cycle; tck stands low between frames
  task automatic tick(input logic m, input logic d, output logic q);
    tms = m;
    // The unused input carries the inverse so a wrong select shows up
    tdi = use_alt ? ~d : d;
    alternate_serial_in = use_alt ? d : ~d;
    last = d;
    #6;
    tck = 1'b1;
    q = tdo;
    #6;
    tck = 1'b0;
  endtask

  task automatic idle(input int n);
    logic q;
    repeat (n) tick(1'b0, ~last, q);
  endtask

  task automatic tap_reset();
    logic q;
    repeat (5) tick(1'b1, ~last, q);
    tick(1'b0, ~last, q);
  endtask

  // ==========================================================
  // Instruction load with no shift, so data pins play no part
  task automatic blind_idcode();
    logic q;
    tick(1'b1, ~last, q);
    tick(1'b1, ~last, q);
    tick(1'b0, ~last, q);
    tick(1'b1, ~last, q);
    tick(1'b1, ~last, q);
    tick(1'b0, ~last, q);
  endtask

  // Instruction or data scan, least significant bit first
  task automatic shift(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic q;
    dout = '0;
    tick(1'b1, ~last, q);
    if (ir)
      tick(1'b1, ~last, q);
    tick(1'b0, ~last, q);
    tick(1'b0, ~last, q);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
    end
    tick(1'b1, ~last, q);
    tick(1'b0, ~last, q);
  endtask
endmodule

/* sim/test_jtag_prog_port.sv */
/*
  Self-checking bench of the serial programming port: output gating, scans,
  alternate input selection and the nonvolatile programming flow.
  Assumes jtag_host_model drives the link and the pad pull-up is modelled as a driven 1.
*/
`timescale 1ns/1ns

module test_jtag_prog_port
  import jtag_prog_pkg::*;
();
  // Identification value is arbitrary
  localparam logic [31:0] ID_ARB = 32'h6B2E_9A41;
  localparam logic [31:0] CFG_D = 32'hC3A5_0F96;
  localparam logic [31:0] UES_D = 32'h1E2D_3C4B;

  logic sys_clk = 1'b0;
  logic nrst;
  logic strap;
  logic ps;
  logic mo;
  logic [15:0] cdo;
  logic [15:0] coe;
  logic [3:0] chv;
  logic [3:0] fet;
  logic [5:0] pins;
  logic tck;
  logic tms;
  logic tdi;
  logic alt_in;
  logic tdo;
  logic tdo_oe;
  int oe_seen = 0;
  logic [5:0] core_in;
  logic [15:0] dig_out;
  logic [15:0] dig_oe;
  logic [3:0] hv_out;
  logic [3:0] hv_oe;
  logic alt_input_active;
  logic program_mode;
  nv_s nv_content;
  int failures = 0;
  int checks_done = 0;

  // Inputs {ps, mo, cdo, coe, chv, fet} beside outputs {dig_out, dig_oe, hv, hv_oe, core_in}
  logic [87:0] rows [4] = '{
    {1'b0, 1'b1, 16'hA5C3, 16'h0FF0, 4'hB, 4'h3, 16'hA5C3, 16'h0FF0, 4'hB, 4'hF, 6'h2D},
    {1'b1, 1'b0, 16'hA5C3, 16'h0FF0, 4'hB, 4'h3, 16'h0000, 16'h0000, 4'h0, 4'h3, 6'h00},
    {1'b1, 1'b1, 16'hFFFF, 16'hFFFF, 4'hF, 4'hC, 16'hFFFF, 16'hFFFF, 4'hF, 4'hF, 6'h2D},
    {1'b1, 1'b0, 16'hFFFF, 16'hFFFF, 4'hF, 4'hC, 16'h0000, 16'h0000, 4'h0, 4'hC, 6'h00}
  };

  always #5 sys_clk = ~sys_clk;

  // Counts link rises at which the design drives TDO
  always @(posedge tck)
  begin
    if (tdo_oe === 1'b1)
      oe_seen++;
  end

  jtag_host_model i_host (.tck(tck), .tms(tms), .tdi(tdi), .alternate_serial_in(alt_in), .tdo(tdo));

  jtag_prog_port #(.ID_VALUE(ID_ARB)) i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi), .alternate_serial_in(alt_in),
    .input_select_strap(strap), .tdo(tdo), .tdo_oe(tdo_oe), .programming_supply_pin(ps), .main_supply_on(mo),
    .core_dig_out(cdo), .core_dig_oe(coe), .core_hv_out(chv), .hv_fet_mode(fet), .core_in(core_in),
    .pin_in(pins), .dig_out(dig_out), .dig_oe(dig_oe), .high_voltage_output(hv_out), .hv_oe(hv_oe),
    .alt_input_active(alt_input_active), .program_mode(program_mode), .nv_content(nv_content)
  );

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [64:0] seen, input logic [64:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (failures == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic sys(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic ir(input logic [7:0] code);
    logic [31:0] q;
    i_host.shift(1'b1, 8, {24'h0, code}, q);
    check(65'(q[7:0]), 65'h16);
  endtask

  // Bypass delays by one bit behind a captured zero
  task automatic bypass_chk();
    logic [31:0] q;
    int n;
    ir(8'hFF);
    n = oe_seen;
    i_host.shift(1'b0, 8, 32'h5A, q);
    check(65'(q[7:0]), 65'hB4);
    check(65'(oe_seen - n), 65'h8);
  endtask

  task automatic prog(input logic [7:0] sh, input logic [7:0] pr, input logic [31:0] d);
    logic [31:0] q;
    ir(sh);
    i_host.shift(1'b0, 32, d, q);
    ir(pr);
    i_host.idle(10);
    sys(4);
  endtask

  initial
  begin
    #200000;
    failures++;
    end_sim();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [31:0] q;
    nrst = 1'b0;
    strap = 1'b1;
    {ps, mo, cdo, coe, chv, fet} = {1'b0, 1'b1, 40'h0};
    pins = 6'h2D;
    fork
      sys(8);
      i_host.tap_reset();
    join
    check(65'(nv_content), {64'hFFFF_FFFF_FFFF_FFFF, 1'b0});
    check(65'({alt_input_active, program_mode, dig_out, dig_oe, hv_oe, core_in}), 65'h0);
    nrst = 1'b1;
    i_host.idle(3);
    for (int i = 0; i < 4; i++)
    begin
      {ps, mo, cdo, coe, chv, fet} = rows[i][87:46];
      sys(6);
      check(65'({dig_out, dig_oe, hv_out, hv_oe, core_in}), 65'(rows[i][45:0]));
    end
    {ps, mo} = 2'b01;
    i_host.shift(1'b0, 32, 32'h0, q);
    check(65'(q), 65'(ID_ARB));
    bypass_chk();
    pins = 6'h13;
    ir(8'h1C);
    i_host.shift(1'b0, 6, 32'h0, q);
    check(65'(q[5:0]), 65'h13);
    ir(8'h18);
    // The high-impedance flag is a link register, so the link must step once more
    i_host.idle(2);
    sys(8);
    check(65'({dig_oe, hv_oe}), 65'({16'h0, fet}));
    // An interrupted run must start counting again
    repeat (3) i_host.blind_idcode();
    ir(8'hFF);
    repeat (3) i_host.blind_idcode();
    sys(6);
    check(65'(alt_input_active), 65'h0);
    i_host.blind_idcode();
    i_host.use_alt = 1'b1;
    sys(6);
    check(65'(alt_input_active), 65'h1);
    bypass_chk();
    i_host.use_alt = 1'b0;
    i_host.tap_reset();
    sys(6);
    check(65'(alt_input_active), 65'h0);
    i_host.shift(1'b0, 32, 32'h0, q);
    check(65'(q), 65'(ID_ARB));
    strap = 1'b0;
    i_host.use_alt = 1'b1;
    i_host.idle(4);
    i_host.tap_reset();
    sys(6);
    check(65'(alt_input_active), 65'h1);
    bypass_chk();
    strap = 1'b1;
    i_host.idle(4);
    i_host.use_alt = 1'b0;
    sys(6);
    check(65'(alt_input_active), 65'h0);
    // Programming flow
    ir(8'h15);
    sys(6);
    check(65'(program_mode), 65'h1);
    prog(8'h2D, 8'h2E, CFG_D);
    check(65'(nv_content.cfg), 65'(CFG_D));
    ir(8'h2D);
    i_host.shift(1'b0, 32, 32'h0, q);
    check(65'(q), 65'(CFG_D));
    prog(8'h3A, 8'h3B, UES_D);
    check(65'(nv_content.user_signature), 65'(UES_D));
    ir(8'h09);
    i_host.idle(10);
    sys(4);
    check(65'(nv_content.fuse), 65'h1);
    ir(8'h2D);
    i_host.shift(1'b0, 32, 32'h0, q);
    check(65'(q), 65'h0);
    ir(8'h03);
    i_host.idle(10);
    sys(4);
    check(65'(nv_content), {64'hFFFF_FFFF_FFFF_FFFF, 1'b0});
    ir(8'h1E);
    sys(6);
    check(65'(program_mode), 65'h0);
    prog(8'h2D, 8'h2E, CFG_D);
    check(65'(nv_content.cfg), 65'hFFFF_FFFF);
    end_sim();
  end
endmodule
